// ==== design/tcf_torque_cutoff_fault_latch.sv ====
// Overview of operation
// - cutoff always active, no setting disables it
// - cutoff while enabled latches resettable fault
// - enable request during cutoff latches same fault
// - cutoff while idle clears itself on release
// - latched fault survives release until reset
// - statusword bit 3 flags faults, code published
// - controlword bit 7 rising edge means reset
// - reset with cutoff released clears, enables resume
// - diagnostic failure: sticky safety fault, power only
// - supply out of limits: sticky safety fault
// - reported status never feeds the torque path
// - cutoff means no torque, enables refused
`timescale 1ns/1ps
`default_nettype none

module tcf_torque_cutoff_fault_latch (
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_sys_rst,
    input  wire logic [tcf_pkg::TCF_ADDR_W-1:0] i_avs_address,
    input  wire logic                          i_avs_read,
    input  wire logic                          i_avs_write,
    input  wire logic [tcf_pkg::TCF_DATA_W-1:0] i_avs_writedata,
    input  wire logic [3:0]                    i_avs_byteenable,
    output logic      [tcf_pkg::TCF_DATA_W-1:0] o_avs_readdata,
    output logic                               o_avs_waitrequest,
    input  wire logic                          i_torque_cutoff,
    input  wire logic                          i_diag_fail,
    input  wire logic                          i_supply_fault,
    output logic                               o_torque_en,
    output logic                               o_fault_halt_flag,
    output logic                               o_irq
);
    import tcf_pkg::*;

    tcf_bus_e                bus_state;
    tcf_bus_e                next_bus_state;
    logic                    next_waitrequest;
    logic [31:0]             next_readdata;
    logic                    wr_en;
    logic                    reset_pulse;

    logic                    ctrl_enable;
    logic                    ctrl_reset;
    logic                    cfg_alt;
    logic [TCF_IRQ_W-1:0]    irq_mask;
    logic                    next_ctrl_enable;
    logic                    next_ctrl_reset;
    logic                    next_cfg_alt;
    logic [TCF_IRQ_W-1:0]    next_irq_mask;

    tcf_faults_s             faults;
    tcf_faults_s             next_faults;
    logic                    enabled;
    logic                    next_enabled;
    logic                    cutoff_prev;
    logic                    next_torque_en;
    logic                    next_fault_halt;
    logic                    cut_set;
    logic                    safety;

    logic [TCF_IRQ_W-1:0]    irq_sts;
    logic [TCF_IRQ_W-1:0]    next_irq_sts;
    logic [TCF_IRQ_W-1:0]    irq_event;
    logic [TCF_IRQ_W-1:0]    irq_clear;
    logic                    next_irq;

    tcf_status_s             status;
    logic [15:0]             err_code;

    // ---------------- reported status and fault code ----------------
    always_comb begin
        safety = faults.diag_fault | faults.supply_fault;
        status = '{rsvd: 12'h000,
                   fault: faults.cut_fault | safety,
                   safety_fault: safety,
                   cutoff_active_flag: i_torque_cutoff,
                   drive_enabled: enabled};
        // safety-class faults outrank the resettable one in the code object
        if (faults.diag_fault) begin
            err_code = cfg_alt ? TCF_ERR_DIAG_ALT : TCF_ERR_DIAG;
        end else if (faults.supply_fault) begin
            err_code = cfg_alt ? TCF_ERR_SUPPLY_ALT : TCF_ERR_SUPPLY;
        end else if (faults.cut_fault) begin
            err_code = cfg_alt ? TCF_ERR_CUT_ALT : TCF_ERR_CUT;
        end else begin
            err_code = TCF_ERR_NONE;
        end
    end

    // ---------------- avalon slave ----------------
    always_comb begin
        next_bus_state = bus_state;
        next_readdata  = o_avs_readdata;
        unique case (bus_state)
            TCF_BUS_IDLE: begin
                if (i_avs_read || i_avs_write) begin
                    next_bus_state = TCF_BUS_ACK;
                    next_readdata  = 32'h0000_0000;
                    unique case (i_avs_address)
                        TCF_REG_CTRL:     next_readdata[7:0] = {ctrl_reset, 6'h00, ctrl_enable};
                        TCF_REG_STATUS:   next_readdata[15:0] = status;
                        TCF_REG_ERR_CODE: next_readdata[15:0] = err_code;
                        TCF_REG_IRQ_STS:  next_readdata[TCF_IRQ_W-1:0] = irq_sts;
                        TCF_REG_IRQ_MASK: next_readdata[TCF_IRQ_W-1:0] = irq_mask;
                        TCF_REG_CFG:      next_readdata[TCF_CFG_ALT_CODES] = cfg_alt;
                        default:          next_readdata = 32'h0000_0000;
                    endcase
                end
            end
            TCF_BUS_ACK: begin
                next_bus_state = TCF_BUS_IDLE;
            end
        endcase
        next_waitrequest = (next_bus_state != TCF_BUS_ACK);
        // a write lands only at the edge where waitrequest is seen low
        wr_en = i_avs_write && (bus_state == TCF_BUS_ACK) && i_avs_byteenable[0];
        // edge against the stored bit, so a held-high bit never re-fires
        reset_pulse = wr_en && (i_avs_address == TCF_REG_CTRL)
                      && i_avs_writedata[TCF_CTRL_RESET] && !ctrl_reset;
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bus_state         <= TCF_BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= TCF_RDATA_RST;
        end else begin
            bus_state         <= next_bus_state;
            o_avs_waitrequest <= next_waitrequest;
            o_avs_readdata    <= next_readdata;
        end
    end

    // ---------------- software registers ----------------
    // no register here can mask or bypass the cutoff input
    always_comb begin
        next_ctrl_enable = ctrl_enable;
        next_ctrl_reset  = ctrl_reset;
        next_cfg_alt     = cfg_alt;
        next_irq_mask    = irq_mask;
        if (wr_en) begin
            unique case (i_avs_address)
                TCF_REG_CTRL: begin
                    next_ctrl_enable = i_avs_writedata[TCF_CTRL_ENABLE];
                    next_ctrl_reset  = i_avs_writedata[TCF_CTRL_RESET];
                end
                TCF_REG_IRQ_MASK: next_irq_mask = i_avs_writedata[TCF_IRQ_W-1:0];
                TCF_REG_CFG:      next_cfg_alt  = i_avs_writedata[TCF_CFG_ALT_CODES];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_enable <= 1'b0;
            ctrl_reset  <= 1'b0;
            cfg_alt     <= 1'b0;
            irq_mask    <= TCF_MASK_RST;
        end else begin
            ctrl_enable <= next_ctrl_enable;
            ctrl_reset  <= next_ctrl_reset;
            cfg_alt     <= next_cfg_alt;
            irq_mask    <= next_irq_mask;
        end
    end

    // ---------------- fault latch and torque gate ----------------
    always_comb begin
        next_faults = faults;
        // cutoff while running, or an enable request under cutoff
        cut_set = i_torque_cutoff && (enabled || ctrl_enable);
        if (cut_set) begin
            next_faults.cut_fault = 1'b1;
        end else if (reset_pulse && !i_torque_cutoff) begin
            next_faults.cut_fault = 1'b0;
        end
        // cleared by power-on reset only, never by the controlword
        next_faults.diag_fault   = faults.diag_fault | i_diag_fail;
        next_faults.supply_fault = faults.supply_fault | i_supply_fault;
        // idle cutoff with no request leaves no fault behind
        next_enabled = ctrl_enable && !i_torque_cutoff && !faults.cut_fault
                       && !safety && !i_diag_fail && !i_supply_fault;
        // torque gate looks at the input itself, not at reported status
        next_torque_en  = next_enabled && !i_torque_cutoff;
        next_fault_halt = next_faults.cut_fault | next_faults.diag_fault | next_faults.supply_fault;
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            faults            <= '{cut_fault: 1'b0, diag_fault: 1'b0, supply_fault: 1'b0};
            enabled           <= 1'b0;
            cutoff_prev       <= 1'b0;
            o_torque_en       <= 1'b0;
            o_fault_halt_flag <= 1'b0;
        end else begin
            faults            <= next_faults;
            enabled           <= next_enabled;
            cutoff_prev       <= i_torque_cutoff;
            o_torque_en       <= next_torque_en;
            o_fault_halt_flag <= next_fault_halt;
        end
    end

    // ---------------- interrupt status ----------------
    always_comb begin
        irq_event = 3'h0;
        irq_event[TCF_IRQ_CUT_FAULT] = cut_set && !faults.cut_fault;
        irq_event[TCF_IRQ_SAFETY]    = (i_diag_fail || i_supply_fault) && !safety;
        irq_event[TCF_IRQ_CUTOFF_IN] = i_torque_cutoff && !cutoff_prev;
        irq_clear = 3'h0;
        if (wr_en && (i_avs_address == TCF_REG_IRQ_STS)) begin
            irq_clear = i_avs_writedata[TCF_IRQ_W-1:0];
        end
        // set wins over a write-one-to-clear in the same cycle
        next_irq_sts = (irq_sts & ~irq_clear) | irq_event;
        next_irq     = |(next_irq_sts & next_irq_mask);
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_sts <= TCF_STS_RST;
            o_irq   <= 1'b0;
        end else begin
            irq_sts <= next_irq_sts;
            o_irq   <= next_irq;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    chk_cutoff_no_torque: assert property (i_torque_cutoff |=> !o_torque_en && !enabled)
        else $error("torque present while cutoff asserted");

    chk_run_cutoff_latch: assert property (i_torque_cutoff && enabled |=> faults.cut_fault)
        else $error("cutoff while enabled did not latch fault");

    chk_request_latch: assert property (i_torque_cutoff && ctrl_enable |=> faults.cut_fault && !enabled)
        else $error("enable request under cutoff did not latch fault");

    chk_idle_recovery: assert property (!faults.cut_fault && !safety && !i_torque_cutoff && !i_diag_fail
                                        && !i_supply_fault && ctrl_enable |=> enabled && o_torque_en)
        else $error("drive did not resume without reset");

    chk_fault_holds: assert property (faults.cut_fault && !reset_pulse |=> faults.cut_fault && !enabled)
        else $error("cutoff fault dropped without reset");

    chk_status_code: assert property (status.fault == (err_code != TCF_ERR_NONE))
        else $error("statusword fault bit disagrees with fault code");

    chk_reset_clears: assert property (faults.cut_fault && reset_pulse && !i_torque_cutoff
                                       |=> !faults.cut_fault && err_code != TCF_ERR_CUT)
        else $error("valid reset did not clear cutoff fault");

    chk_safety_sticky: assert property (safety |=> safety [*8])
        else $error("safety fault cleared without power cycle");

    chk_reset_blocked: assert property (reset_pulse && i_torque_cutoff && faults.cut_fault
                                        |=> faults.cut_fault)
        else $error("reset under cutoff cleared the fault");

    chk_alt_code: assert property (faults.cut_fault && !safety && cfg_alt |-> err_code == TCF_ERR_CUT_ALT)
        else $error("alternative cutoff code wrong");

    chk_irq_level: assert property (o_irq == ((irq_sts & irq_mask) != 3'h0))
        else $error("interrupt level disagrees with masked status");

    // every fault source shows on the halt flag and blocks torque
    chk_halt_flag: assert property (o_fault_halt_flag
                                    == (faults.cut_fault || faults.diag_fault || faults.supply_fault))
        else $error("halt flag disagrees with latched faults");

    chk_gate_faults: assert property (o_torque_en |-> !faults.cut_fault && !safety)
        else $error("torque allowed while a fault is latched");

    chk_safety_disable: assert property (i_diag_fail || i_supply_fault
                                         |=> !enabled && !o_torque_en)
        else $error("drive stayed enabled after safety failure");

    chk_no_torque_safety: assert property (safety |-> !o_torque_en)
        else $error("torque allowed under safety fault");

    chk_diag_latch: assert property (i_diag_fail |=> faults.diag_fault)
        else $error("diagnostic failure not latched");

    chk_supply_latch: assert property (i_supply_fault |=> faults.supply_fault)
        else $error("supply failure not latched");

    // code priority: diagnostic, then supply, then cutoff
    chk_diag_code: assert property (faults.diag_fault
                                    |-> err_code == (cfg_alt ? TCF_ERR_DIAG_ALT : TCF_ERR_DIAG))
        else $error("diagnostic fault code wrong");

    chk_supply_code: assert property (faults.supply_fault && !faults.diag_fault
                                      |-> err_code == (cfg_alt ? TCF_ERR_SUPPLY_ALT : TCF_ERR_SUPPLY))
        else $error("supply fault code wrong");

    chk_primary_code: assert property (faults.cut_fault && !safety && !cfg_alt |-> err_code == TCF_ERR_CUT)
        else $error("primary cutoff code wrong");

    chk_code_holds: assert property (faults.cut_fault && !reset_pulse |=> err_code != TCF_ERR_NONE)
        else $error("fault code vanished without reset");

    chk_idle_no_fault: assert property (i_torque_cutoff && !enabled && !ctrl_enable
                                        && !faults.cut_fault |=> !faults.cut_fault)
        else $error("idle cutoff latched a fault");

    chk_enable_gated: assert property (enabled |-> $past(ctrl_enable) && !$past(i_torque_cutoff))
        else $error("drive enabled without request or under cutoff");

    // interrupt events, a same-cycle clear never hides a new one
    chk_irq_cut_event: assert property (i_torque_cutoff && enabled && !faults.cut_fault
                                        |=> irq_sts[TCF_IRQ_CUT_FAULT])
        else $error("cutoff fault latch raised no interrupt status");

    chk_irq_safety_event: assert property ((i_diag_fail || i_supply_fault) && !safety
                                           |=> irq_sts[TCF_IRQ_SAFETY])
        else $error("safety fault raised no interrupt status");

    chk_irq_input_event: assert property (i_torque_cutoff && !cutoff_prev |=> irq_sts[TCF_IRQ_CUTOFF_IN])
        else $error("cutoff input edge raised no interrupt status");

    // bus handshake: one wait state, then one acknowledge cycle
    chk_wait_answer: assert property (bus_state == TCF_BUS_IDLE && (i_avs_read || i_avs_write)
                                      |=> !o_avs_waitrequest)
        else $error("request not answered after one wait state");

    chk_wait_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("acknowledge longer than one cycle");

    chk_rdata_hold: assert property (bus_state == TCF_BUS_ACK |=> $stable(o_avs_readdata))
        else $error("read data moved during acknowledge");

    cov_run_cutoff: cover property (enabled ##1 i_torque_cutoff ##[1:20] faults.cut_fault);
    cov_reset_clear: cover property (faults.cut_fault ##1 !faults.cut_fault ##[1:20] enabled);
    cov_safety: cover property ($rose(safety));
    cov_idle_cutoff: cover property (!ctrl_enable && i_torque_cutoff ##1 !i_torque_cutoff && !faults.cut_fault);
    cov_request_latch: cover property (!enabled && ctrl_enable && i_torque_cutoff ##1 faults.cut_fault);

endmodule : tcf_torque_cutoff_fault_latch

`default_nettype wire

// ==== design/tcf_pkg.sv ====
package tcf_pkg;

    localparam int          TCF_ADDR_W        = 8;
    localparam int          TCF_DATA_W        = 32;
    localparam int          TCF_IRQ_W         = 3;

    // register byte offsets
    localparam logic [7:0]  TCF_REG_CTRL      = 8'h00;
    localparam logic [7:0]  TCF_REG_STATUS    = 8'h04;
    localparam logic [7:0]  TCF_REG_ERR_CODE  = 8'h08;
    localparam logic [7:0]  TCF_REG_IRQ_STS   = 8'h0C;
    localparam logic [7:0]  TCF_REG_IRQ_MASK  = 8'h10;
    localparam logic [7:0]  TCF_REG_CFG       = 8'h14;

    // field positions
    localparam int          TCF_CTRL_ENABLE   = 0;
    localparam int          TCF_CTRL_RESET    = 7;
    localparam int          TCF_CFG_ALT_CODES = 0;
    localparam int          TCF_IRQ_CUT_FAULT = 0;
    localparam int          TCF_IRQ_SAFETY    = 1;
    localparam int          TCF_IRQ_CUTOFF_IN = 2;

    // reset values
    localparam logic [TCF_IRQ_W-1:0] TCF_MASK_RST = 3'h0;
    localparam logic [TCF_IRQ_W-1:0] TCF_STS_RST  = 3'h0;
    localparam logic [31:0] TCF_RDATA_RST     = 32'h0000_0000;

    // fault codes, primary set and alternative set
    localparam logic [15:0] TCF_ERR_NONE      = 16'h0000;
    localparam logic [15:0] TCF_ERR_CUT       = 16'hFF80;
    localparam logic [15:0] TCF_ERR_CUT_ALT   = 16'h011E;
    localparam logic [15:0] TCF_ERR_DIAG      = 16'hFF81;
    localparam logic [15:0] TCF_ERR_DIAG_ALT  = 16'h011F;
    localparam logic [15:0] TCF_ERR_SUPPLY    = 16'hFF85;
    localparam logic [15:0] TCF_ERR_SUPPLY_ALT = 16'h0120;

    typedef enum logic {
        TCF_BUS_IDLE,
        TCF_BUS_ACK
    } tcf_bus_e;

    // statusword layout, bit 3 is the fault flag
    typedef struct packed {
        logic [11:0] rsvd;
        logic        fault;
        logic        safety_fault;
        logic        cutoff_active_flag;
        logic        drive_enabled;
    } tcf_status_s;

    typedef struct packed {
        logic        cut_fault;
        logic        diag_fault;
        logic        supply_fault;
    } tcf_faults_s;

endpackage : tcf_pkg

// ==== test/tcf_safety_src.sv ====
`timescale 1ns/1ps
`default_nettype none

// behavioural source of the safety inputs; levels settle right after a clock edge
module tcf_safety_src (
    input  wire logic i_sys_clk,
    input  wire logic i_cut_req,
    input  wire logic i_diag_req,
    input  wire logic i_supply_req,
    output logic      o_torque_cutoff,
    output logic      o_diag_fail,
    output logic      o_supply_fault
);
    // one shared cutoff line, every drive on it sees the same edge
    always_ff @(posedge i_sys_clk) begin
        o_torque_cutoff <= i_cut_req;
        o_diag_fail     <= i_diag_req;
        o_supply_fault  <= i_supply_req;
    end
endmodule : tcf_safety_src

`default_nettype wire

// ==== test/tcf_testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end

module testbench;
    import tcf_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wt;
    logic        cut_req = 1'b0;
    logic        diag_req = 1'b0;
    logic        sup_req = 1'b0;
    logic        cut, diag, sup, ten, halt, irq;
    logic [31:0] rv;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #50 clk = ~clk;

    tcf_safety_src u_src (.i_sys_clk(clk), .i_cut_req(cut_req), .i_diag_req(diag_req),
        .i_supply_req(sup_req), .o_torque_cutoff(cut), .o_diag_fail(diag), .o_supply_fault(sup));

    tcf_torque_cutoff_fault_latch uut (.i_sys_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_torque_cutoff(cut), .i_diag_fail(diag),
        .i_supply_fault(sup), .o_torque_en(ten), .o_fault_halt_flag(halt), .o_irq(irq));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("[FAIL] %0t run did not finish", $time);
            complete_run();
        end
    end

    // request held until waitrequest is seen low at a rising edge
    // no local limit: only the hang guard ends a wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (wt !== 1'b0);
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        `CHK(rv, exp)
    endtask : rd_chk

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic set_cut(input logic v);
        @(posedge clk);
        cut_req <= v;
        step(3);
    endtask : set_cut

    // the only way out of a safety fault is a full reset
    task automatic power_cycle();
        @(posedge clk); rst <= 1'b1;
        step(6);
        rst <= 1'b0;
        step(1);
    endtask : power_cycle

    task automatic t_reset_values();
        rd_chk(TCF_REG_STATUS, 32'h0);
        rd_chk(TCF_REG_ERR_CODE, 32'h0);
        wr_reg(8'h20, 32'hFFFF_FFFF);
        rd_chk(8'h20, 32'h0);
        `CHK(ten, 1'b0)
        `CHK(irq, 1'b0)
    endtask : t_reset_values

    task automatic t_idle_cutoff();
        set_cut(1'b1);
        rd_chk(TCF_REG_STATUS, 32'h2);
        set_cut(1'b0);
        rd_chk(TCF_REG_STATUS, 32'h0);
        rd_chk(TCF_REG_ERR_CODE, {16'h0, TCF_ERR_NONE});
        wr_reg(TCF_REG_CTRL, 32'h1);
        step(3);
        `CHK(ten, 1'b1)
        rd_chk(TCF_REG_STATUS, 32'h1);
    endtask : t_idle_cutoff

    task automatic t_run_cutoff();
        wr_reg(TCF_REG_IRQ_MASK, 32'h1);
        rd_chk(TCF_REG_IRQ_MASK, 32'h1);
        set_cut(1'b1);
        `CHK(ten, 1'b0)
        `CHK(halt, 1'b1)
        `CHK(irq, 1'b1)
        rd_chk(TCF_REG_ERR_CODE, {16'h0, TCF_ERR_CUT});
        rd_chk(TCF_REG_STATUS, 32'hA);
        wr_reg(TCF_REG_CTRL, 32'h81);
        set_cut(1'b0);
        rd_chk(TCF_REG_ERR_CODE, {16'h0, TCF_ERR_CUT});
        `CHK(ten, 1'b0)
        wr_reg(TCF_REG_CTRL, 32'h81);
        step(3);
        `CHK(halt, 1'b1)
        rd_chk(TCF_REG_CTRL, 32'h81);
        wr_reg(TCF_REG_CTRL, 32'h01);
        wr_reg(TCF_REG_CTRL, 32'h81);
        step(3);
        `CHK(halt, 1'b0)
        `CHK(ten, 1'b1)
        rd_chk(TCF_REG_ERR_CODE, 32'h0);
        rd_chk(TCF_REG_IRQ_STS, 32'h5);
        wr_reg(TCF_REG_IRQ_STS, 32'h7);
        step(2);
        `CHK(irq, 1'b0)
        rd_chk(TCF_REG_IRQ_STS, 32'h0);
        wr_reg(TCF_REG_CTRL, 32'h00);
    endtask : t_run_cutoff

    task automatic t_enable_in_cutoff();
        wr_reg(TCF_REG_CFG, 32'h1);
        rd_chk(TCF_REG_CFG, 32'h1);
        set_cut(1'b1);
        rd_chk(TCF_REG_ERR_CODE, 32'h0);
        wr_reg(TCF_REG_CTRL, 32'h1);
        step(3);
        rd_chk(TCF_REG_ERR_CODE, {16'h0, TCF_ERR_CUT_ALT});
        `CHK(ten, 1'b0)
        set_cut(1'b0);
        `CHK(ten, 1'b0)
        wr_reg(TCF_REG_CTRL, 32'h0);
        wr_reg(TCF_REG_CTRL, 32'h80);                       // host reset via controlword bit 7
        step(3);
        rd_chk(TCF_REG_ERR_CODE, 32'h0);
        `CHK(halt, 1'b0)
        wr_reg(TCF_REG_CFG, 32'h0);
    endtask : t_enable_in_cutoff

    task automatic t_safety_faults();
        @(posedge clk);
        diag_req <= 1'b1;
        @(posedge clk);
        diag_req <= 1'b0;
        step(3);
        rd_chk(TCF_REG_ERR_CODE, {16'h0, TCF_ERR_DIAG});
        rd_chk(TCF_REG_STATUS, 32'hC);
        rd_chk(TCF_REG_IRQ_STS, 32'h7);
        wr_reg(TCF_REG_CTRL, 32'h0);
        wr_reg(TCF_REG_CTRL, 32'h80);
        step(3);
        `CHK(halt, 1'b1)
        power_cycle();
        rd_chk(TCF_REG_ERR_CODE, 32'h0);
        wr_reg(TCF_REG_CFG, 32'h1);
        @(posedge clk);
        sup_req <= 1'b1;
        @(posedge clk);
        sup_req <= 1'b0;
        step(3);
        rd_chk(TCF_REG_ERR_CODE, {16'h0, TCF_ERR_SUPPLY_ALT});
        rd_chk(TCF_REG_IRQ_STS, 32'h2);
        wr_reg(TCF_REG_CTRL, 32'h80);
        step(3);
        `CHK(halt, 1'b1)
        power_cycle();
        `CHK(halt, 1'b0)
    endtask : t_safety_faults

    initial begin
        step(6);
        rst <= 1'b0;
        step(1);
        t_reset_values();
        t_idle_cutoff();
        t_run_cutoff();
        t_enable_in_cutoff();
        t_safety_faults();
        complete_run();
    end
endmodule : testbench

`default_nettype wire
